// ### hdl/nip_top.sv
// Interrupt pending, active and priority logic with its APB register file
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "nip_cfg.svh"
module nip_top #(
  parameter int NUM_SRC = 36,
  parameter int PRIO_W  = 3
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Peripheral request lines and non-maskable request
  input  wire logic [NUM_SRC-1:0]   irq_line,
  input  wire logic                 nmi_line,
  // Core exception events
  input  wire logic                 core_enter,
  input  wire nip_pkg::nip_id_t     core_enter_id,
  input  wire logic                 core_return,
  input  wire nip_pkg::nip_id_t     core_return_id,
  input  wire logic                 nmi_enter,
  input  wire logic                 nmi_return,
  // Presentation to the core
  output logic                      irq_req,
  output nip_pkg::nip_id_t          irq_id,
  output logic [PRIO_W-1:0]         irq_prio,
  output logic [PRIO_W-1:0]         irq_group,
  output logic                      nmi_req,
  output logic                      ctx_save,
  output logic                      ctx_restore,
  // Event interrupt
  output logic                      irq_out
);
  import nip_pkg::*;

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (NUM_SRC < 1 || NUM_SRC > 64) begin : g_bad_num
    $error("NUM_SRC must be 1 to 64");
  end
  if (PRIO_W < 1 || PRIO_W > 8) begin : g_bad_prio
    $error("PRIO_W must be 1 to 8");
  end

  localparam int PADW = 64 - NUM_SRC;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0]    en_reg;
  logic [NUM_SRC-1:0]    mode_reg;
  logic [PRIO_W-1:0]     prio_reg [NUM_SRC];
  logic [2:0]            prigrp_reg;
  logic [`NIP_EV_W-1:0]  istat_reg;
  logic [`NIP_EV_W-1:0]  ien_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  nmi_prev_reg;
  logic                  nmi_pend_reg;
  logic                  nmi_act_reg;
  logic                  irq_req_reg;
  nip_id_t               irq_id_reg;
  logic [PRIO_W-1:0]     irq_prio_reg;
  logic [PRIO_W-1:0]     irq_group_reg;
  logic                  ctx_save_reg;
  logic                  ctx_restore_reg;
  logic                  irq_out_reg;

  nip_state_e            st [NUM_SRC];
  logic [NUM_SRC-1:0]    pend_vec;
  logic [NUM_SRC-1:0]    act_vec;
  logic [NUM_SRC*PRIO_W-1:0] prio_flat;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  wire acc      = psel & penable;
  wire fire     = acc & pready_reg;
  wire wr       = fire & pwrite;
  wire prio_win = (paddr >= `NIP_OFS_PRIO_BASE) && (paddr <= `NIP_OFS_PRIO_TOP) && (paddr[1:0] == 2'b00);
  wire [5:0] prio_idx = paddr[7:2];
  wire prio_hit = prio_win && (int'(prio_idx) < NUM_SRC);

  wire hit_en0   = paddr == `NIP_OFS_EN0;
  wire hit_en1   = paddr == `NIP_OFS_EN1;
  wire hit_sp0   = paddr == `NIP_OFS_SETP0;
  wire hit_sp1   = paddr == `NIP_OFS_SETP1;
  wire hit_cp0   = paddr == `NIP_OFS_CLRP0;
  wire hit_cp1   = paddr == `NIP_OFS_CLRP1;
  wire hit_ac0   = paddr == `NIP_OFS_ACT0;
  wire hit_ac1   = paddr == `NIP_OFS_ACT1;
  wire hit_md0   = paddr == `NIP_OFS_MODE0;
  wire hit_md1   = paddr == `NIP_OFS_MODE1;
  wire hit_swt   = paddr == `NIP_OFS_SOFTWARE_TRIGGER_REG;
  wire hit_grp   = paddr == `NIP_OFS_PRIGRP;
  wire hit_vect  = paddr == `NIP_OFS_VECT;
  wire hit_ist   = paddr == `NIP_OFS_ISTAT;
  wire hit_ien   = paddr == `NIP_OFS_IEN;
  wire hit_iclr  = paddr == `NIP_OFS_ICLR;
  wire mapped    = hit_en0 | hit_en1 | hit_sp0 | hit_sp1 | hit_cp0 | hit_cp1 | hit_ac0 | hit_ac1 |
                   hit_md0 | hit_md1 | hit_swt | hit_grp | hit_vect | hit_ist | hit_ien | hit_iclr | prio_hit;

  // ------------------------------------------------------------
  // Bank write vectors, 64 bits wide, sliced to the source count
  // ------------------------------------------------------------
  wire [63:0] en_wide   = {{PADW{1'b0}}, en_reg};
  wire [63:0] mode_wide = {{PADW{1'b0}}, mode_reg};
  wire [63:0] pend_wide = {{PADW{1'b0}}, pend_vec};
  wire [63:0] act_wide  = {{PADW{1'b0}}, act_vec};

  wire [63:0] en_w      = (wr & hit_en0) ? {en_wide[63:32], pwdata} :
                          (wr & hit_en1) ? {pwdata, en_wide[31:0]} : en_wide;
  wire [63:0] mode_w    = (wr & hit_md0) ? {mode_wide[63:32], pwdata} :
                          (wr & hit_md1) ? {pwdata, mode_wide[31:0]} : mode_wide;
  // Trigger names one source by bits 5:0; numbers past the last do nothing
  wire        swt_ok    = wr & hit_swt & (int'(pwdata[5:0]) < NUM_SRC);
  wire [63:0] swt_hot   = swt_ok ? (64'h1 << pwdata[5:0]) : 64'h0;
  wire [63:0] set_w     = ((wr & hit_sp0) ? {32'h0, pwdata} :
                           (wr & hit_sp1) ? {pwdata, 32'h0} : 64'h0) | swt_hot;
  wire [63:0] clr_w     = (wr & hit_cp0) ? {32'h0, pwdata} :
                          (wr & hit_cp1) ? {pwdata, 32'h0} : 64'h0;

  // Core entry and return decoded to one-hot source vectors
  wire [63:0] enter_w   = core_enter  ? (64'h1 << core_enter_id)  : 64'h0;
  wire [63:0] ret_w     = core_return ? (64'h1 << core_return_id) : 64'h0;

  // ------------------------------------------------------------
  // Per-source state machines
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    nip_source u_src (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .req_line   (irq_line[i]),
      .pulse_mode (mode_reg[i]),
      .sw_set     (set_w[i]),
      .sw_clr     (clr_w[i]),
      .enter      (enter_w[i]),
      .ret        (ret_w[i]),
      .state      (st[i])
    );
    assign pend_vec[i] = (st[i] == NIP_PENDING) | (st[i] == NIP_ACT_PEND);
    assign act_vec[i]  = (st[i] == NIP_ACTIVE)  | (st[i] == NIP_ACT_PEND);
    assign prio_flat[i*PRIO_W +: PRIO_W] = prio_reg[i];
  end

  // ------------------------------------------------------------
  // Selection and preemption
  // ------------------------------------------------------------
  logic              pend_found;
  nip_id_t           pend_id;
  logic [PRIO_W-1:0] pend_prio;
  logic              act_found;
  logic [PRIO_W-1:0] act_prio;

  // Most urgent enabled pending source
  nip_arbiter #(.NUM_SRC(NUM_SRC), .PRIO_W(PRIO_W)) u_pend_arb (
    .cand      (pend_vec & en_reg),
    .prio_flat (prio_flat),
    .found     (pend_found),
    .win_id    (pend_id),
    .win_prio  (pend_prio)
  );

  // Most urgent running handler sets the preemption threshold
  nip_arbiter #(.NUM_SRC(NUM_SRC), .PRIO_W(PRIO_W)) u_act_arb (
    .cand      (act_vec),
    .prio_flat (prio_flat),
    .found     (act_found),
    .win_id    (),
    .win_prio  (act_prio)
  );

  // Low bits up to the split point are subpriority and never preempt
  wire [3:0]        sub_bits  = (4'(prigrp_reg) > 4'(PRIO_W)) ? 4'(PRIO_W) : 4'(prigrp_reg);
  wire [PRIO_W-1:0] pend_grp  = pend_prio >> sub_bits;
  wire [PRIO_W-1:0] act_grp   = act_prio >> sub_bits;
  wire              preempt   = pend_found & (~act_found | (pend_grp < act_grp));

  // NMI latched on a rising edge; the set wins over entry
  wire nmi_rise  = nmi_line & ~nmi_prev_reg;
  wire nmi_pend_next = nmi_rise | (nmi_pend_reg & ~nmi_enter);
  wire nmi_act_next  = nmi_enter | (nmi_act_reg & ~nmi_return);

  // ------------------------------------------------------------
  // Event status for the interrupt output
  // ------------------------------------------------------------
  wire [`NIP_EV_W-1:0] ev_set;
  assign ev_set[`NIP_EV_NMI]    = nmi_rise;
  assign ev_set[`NIP_EV_ENTER]  = core_enter | nmi_enter;
  assign ev_set[`NIP_EV_RETURN] = core_return | nmi_return;
  assign ev_set[`NIP_EV_SOFTWARE_TRIGGER_REG] = swt_ok;
  wire [`NIP_EV_W-1:0] ev_clr  = (wr & hit_iclr) ? pwdata[`NIP_EV_W-1:0] : {`NIP_EV_W{1'b0}};
  // New events win over a same-cycle clear
  wire [`NIP_EV_W-1:0] istat_next = ev_set | (istat_reg & ~ev_clr);

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  wire [31:0] vect_word = {irq_req_reg, 7'h00, 8'(irq_group_reg), 8'(irq_prio_reg), 2'b00, irq_id_reg};
  wire [31:0] rd_word   = hit_en0  ? en_wide[31:0]   : hit_en1  ? en_wide[63:32]   :
                          (hit_sp0 | hit_cp0) ? pend_wide[31:0] : (hit_sp1 | hit_cp1) ? pend_wide[63:32] :
                          hit_ac0  ? act_wide[31:0]  : hit_ac1  ? act_wide[63:32]  :
                          hit_md0  ? mode_wide[31:0] : hit_md1  ? mode_wide[63:32] :
                          hit_grp  ? {29'h00000000, prigrp_reg} :
                          hit_vect ? vect_word :
                          hit_ist  ? {{(32-`NIP_EV_W){1'b0}}, istat_reg} :
                          hit_ien  ? {{(32-`NIP_EV_W){1'b0}}, ien_reg} :
                          prio_hit ? {{(32-PRIO_W){1'b0}}, prio_reg[prio_idx]} : 32'h0;

  // ------------------------------------------------------------
  // APB handshake flops
  // ------------------------------------------------------------
  // Read data captured in the first access cycle stands with pready
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `NIP_RST_ZERO32;
    end else begin
      pready_reg  <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~mapped;
      prdata_reg  <= (acc & ~pready_reg & ~pwrite) ? rd_word : '0;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Enables and signalling mode, written whole per bank
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_reg     <= '0;
      mode_reg   <= '0;
      prigrp_reg <= `NIP_RST_PRIGRP;
      ien_reg    <= '0;
      istat_reg  <= '0;
    end else begin
      en_reg     <= en_w[NUM_SRC-1:0];
      mode_reg   <= mode_w[NUM_SRC-1:0];
      prigrp_reg <= (wr & hit_grp) ? pwdata[2:0] : prigrp_reg;
      ien_reg    <= (wr & hit_ien) ? pwdata[`NIP_EV_W-1:0] : ien_reg;
      istat_reg  <= istat_next;
    end
  end

  // Priorities may change at any time; selection follows on the next cycle
  for (genvar p = 0; p < NUM_SRC; p++) begin : g_prio
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) prio_reg[p] <= '0;
      else if (wr & prio_hit & (int'(prio_idx) == p)) prio_reg[p] <= pwdata[PRIO_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Core-facing outputs
  // ------------------------------------------------------------
  // One cycle of latency to the core so every output leaves a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nmi_prev_reg    <= 1'b0;
      nmi_pend_reg    <= 1'b0;
      nmi_act_reg     <= 1'b0;
      irq_req_reg     <= 1'b0;
      irq_id_reg      <= '0;
      irq_prio_reg    <= '0;
      irq_group_reg   <= '0;
      ctx_save_reg    <= 1'b0;
      ctx_restore_reg <= 1'b0;
      irq_out_reg     <= 1'b0;
    end else begin
      nmi_prev_reg    <= nmi_line;
      nmi_pend_reg    <= nmi_pend_next;
      nmi_act_reg     <= nmi_act_next;
      irq_req_reg     <= preempt;
      irq_id_reg      <= pend_id;
      irq_prio_reg    <= pend_prio;
      irq_group_reg   <= pend_grp;
      ctx_save_reg    <= core_enter | nmi_enter;
      ctx_restore_reg <= core_return | nmi_return;
      irq_out_reg     <= |(istat_next & ien_reg);
    end
  end

  // ------------------------------------------------------------
  // Output wiring
  // ------------------------------------------------------------
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign irq_req     = irq_req_reg;
  assign irq_id      = irq_id_reg;
  assign irq_prio    = irq_prio_reg;
  assign irq_group   = irq_group_reg;
  assign nmi_req     = nmi_pend_reg;
  assign ctx_save    = ctx_save_reg;
  assign ctx_restore = ctx_restore_reg;
  assign irq_out     = irq_out_reg;

endmodule

// ### hdl/nip_cfg.svh
// Offsets, fields, reset values and rules of the interrupt pending logic
//
// Contract
// - Each source has a programmable priority; the smallest level is most urgent.
// - Priority splits into group and subpriority parts.
// - Software may rewrite any priority while running.
// - A non-maskable interrupt input exists beside the peripheral sources.
// - Pulse lines are sampled every rising clock edge and a pulse is latched.
// - Line sampled high while the source is not active makes it pending.
// - A rising edge on the request line makes the source pending.
// - A set-pending bit or trigger write makes the source pending; with handler entry in the same cycle the code drops it and goes to active.
// - Handler entry clears pending and marks the source active.
// - Level source on return: line high gives pending, else inactive.
// - Pulse during handler gives active-and-pending; return then gives pending.
// - Pulse source with no new pulse returns to inactive on handler return.
// - Level clear-pending: line high keeps state, line low drops pending.
// - Pulse clear-pending: pending to inactive, active-and-pending to active.
// - Context save on entry and restore on exit happen with no handler code.
`ifndef NIP_CFG_SVH
`define NIP_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define NIP_OFS_EN0       12'h000
`define NIP_OFS_EN1       12'h004
`define NIP_OFS_SETP0     12'h008
`define NIP_OFS_SETP1     12'h00C
`define NIP_OFS_CLRP0     12'h010
`define NIP_OFS_CLRP1     12'h014
`define NIP_OFS_ACT0      12'h018
`define NIP_OFS_ACT1      12'h01C
`define NIP_OFS_MODE0     12'h020
`define NIP_OFS_MODE1     12'h024
`define NIP_OFS_SOFTWARE_TRIGGER_REG    12'h028
`define NIP_OFS_PRIGRP    12'h02C
`define NIP_OFS_VECT      12'h030
`define NIP_OFS_ISTAT     12'h034
`define NIP_OFS_IEN       12'h038
`define NIP_OFS_ICLR      12'h03C
`define NIP_OFS_PRIO_BASE 12'h100
`define NIP_OFS_PRIO_TOP  12'h1FC

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define NIP_EV_NMI        0
`define NIP_EV_ENTER      1
`define NIP_EV_RETURN     2
`define NIP_EV_SOFTWARE_TRIGGER_REG     3
`define NIP_EV_W          4
`define NIP_RST_PRIGRP    3'h0
`define NIP_RST_ZERO32    32'h00000000

`endif

// ### hdl/nip_pkg.sv
// Types shared by the interrupt pending logic
package nip_pkg;

  // Per-source interrupt state, two bits
  typedef enum logic [1:0] {
    NIP_INACTIVE,
    NIP_PENDING,
    NIP_ACTIVE,
    NIP_ACT_PEND
  } nip_state_e;

  // Source number, up to 64 sources
  typedef logic [5:0] nip_id_t;

endpackage

// ### hdl/nip_source.sv
// Per-source pending and active state tracking
`timescale 1ns/1ps
module nip_source (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Request line and mode
  input  wire logic               req_line,
  input  wire logic               pulse_mode,
  // Software and core events
  input  wire logic               sw_set,
  input  wire logic               sw_clr,
  input  wire logic               enter,
  input  wire logic               ret,
  // State
  output nip_pkg::nip_state_e     state
);
  import nip_pkg::*;

  nip_state_e state_reg;
  nip_state_e state_next;
  logic       line_prev_reg;

  // Sampled every edge; a rising edge is remembered as a set event
  wire rise     = req_line & ~line_prev_reg;
  wire lvl_set  = ~pulse_mode & req_line;
  wire any_set  = rise | sw_set;
  // A set arriving with a clear wins over the clear
  wire clr_ok   = sw_clr & ~any_set & ~lvl_set;

  // Next state from current state and events
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NIP_INACTIVE: begin
        if (any_set | lvl_set) state_next = NIP_PENDING;
      end
      NIP_PENDING: begin
        if (enter) state_next = rise ? NIP_ACT_PEND : NIP_ACTIVE;
        else if (clr_ok) state_next = NIP_INACTIVE;
      end
      NIP_ACTIVE: begin
        if (ret) state_next = (pulse_mode ? (rise | sw_set) : (req_line | sw_set)) ? NIP_PENDING : NIP_INACTIVE;
        else if (any_set) state_next = NIP_ACT_PEND;
      end
      NIP_ACT_PEND: begin
        if (ret) state_next = NIP_PENDING;
        else if (clr_ok) state_next = NIP_ACTIVE;
      end
    endcase
  end

  // Inactive after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= NIP_INACTIVE;
      line_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      line_prev_reg <= req_line;
    end
  end

  assign state = state_reg;

endmodule

// ### hdl/nip_arbiter.sv
// Most urgent candidate selection over all sources
`timescale 1ns/1ps
module nip_arbiter #(
  parameter int NUM_SRC = 36,
  parameter int PRIO_W  = 3
) (
  // Candidates and their priorities
  input  wire logic [NUM_SRC-1:0]        cand,
  input  wire logic [NUM_SRC*PRIO_W-1:0] prio_flat,
  // Winner
  output logic                           found,
  output nip_pkg::nip_id_t               win_id,
  output logic [PRIO_W-1:0]              win_prio
);
  import nip_pkg::*;

  // Scan upward with a strict compare so equal levels keep the lower number
  always_comb begin
    found    = 1'b0;
    win_id   = '0;
    win_prio = '1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (cand[i] && (!found || prio_flat[i*PRIO_W +: PRIO_W] < win_prio)) begin
        found    = 1'b1;
        win_id   = nip_id_t'(i);
        win_prio = prio_flat[i*PRIO_W +: PRIO_W];
      end
    end
  end

endmodule

// ### testbench/nip_periph_model.sv
// Peripheral request sources standing beside the interrupt pending logic
`timescale 1ns/1ps
module nip_periph_model #(
  parameter int N = 36
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // One-cycle commands from the bench
  input  wire logic [N-1:0] raise,
  input  wire logic [N-1:0] pulse,
  input  wire logic [N-1:0] done,
  // Request lines
  output logic [N-1:0]      irq_line
);
  logic [N-1:0] held_reg;
  logic [N-1:0] pulse_reg;

  // Level lines stay up until the handler services the source
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      held_reg <= '0;
    end else begin
      held_reg <= (held_reg | raise) & ~done;
    end
  end

  // A pulse lasts one whole clock, the shortest that is reliably seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_reg <= '0;
    end else begin
      pulse_reg <= pulse;
    end
  end

  assign irq_line = held_reg | pulse_reg;
endmodule

// ### testbench/nip_top_monitor.sv
// Concurrent checks on the ports of the interrupt pending logic
`timescale 1ns/1ps
module nip_top_monitor #(
  parameter int NUM_SRC = 36
) (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // Bus answer
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Core events and presentation
  input wire logic             nmi_line,
  input wire logic             core_enter,
  input wire logic             core_return,
  input wire logic             nmi_enter,
  input wire logic             nmi_return,
  input wire logic             nmi_req,
  input wire logic             ctx_save,
  input wire logic             ctx_restore,
  input wire logic             irq_req,
  input wire nip_pkg::nip_id_t irq_id,
  input wire logic             irq_out
);
  import nip_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_rdata_idle; !pready |-> prdata == 32'h00000000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  property p_ctx_save; (core_enter || nmi_enter) |=> ctx_save ##1 !ctx_save; endproperty
  a_ctx_save: assert property (p_ctx_save) else $error("bad save pulse");
  property p_ctx_restore; (core_return || nmi_return) |=> ctx_restore ##1 !ctx_restore; endproperty
  a_ctx_restore: assert property (p_ctx_restore) else $error("bad restore pulse");
  property p_nmi_rise; $rose(nmi_line) |-> ##[1:3] nmi_req; endproperty
  a_nmi_rise: assert property (p_nmi_rise) else $error("nmi edge not latched");
  property p_nmi_clear; (nmi_enter && !nmi_line) |=> !nmi_req; endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("nmi kept after entry");
  property p_reset_idle; $fell(rst) |-> !irq_req && !nmi_req && !irq_out; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("request up after reset");
  property p_id_range; irq_req |-> irq_id < NUM_SRC; endproperty
  a_id_range: assert property (p_id_range) else $error("id out of range");
endmodule

bind nip_top nip_top_monitor #(.NUM_SRC(NUM_SRC)) u_mon (.sys_clk(sys_clk), .rst(rst), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nmi_line(nmi_line), .core_enter(core_enter), .core_return(core_return),
  .nmi_enter(nmi_enter), .nmi_return(nmi_return), .nmi_req(nmi_req), .ctx_save(ctx_save),
  .ctx_restore(ctx_restore), .irq_req(irq_req), .irq_id(irq_id), .irq_out(irq_out));

// ### testbench/tb_nested_interrupt_pending_logic.sv
// Self-checking bench for the interrupt pending logic
`timescale 1ns/1ps
`include "nip_cfg.svh"
module tb_nested_interrupt_pending_logic;
  import nip_pkg::*;
  localparam int N = 36;
  // Event command bits: enter, return, nmi entry, nmi line, level, pulse, serviced
  localparam logic [6:0] ent = 7'h01, ret = 7'h02, nen = 7'h04, nln = 7'h08, lvl = 7'h10, pls = 7'h20, dne = 7'h40;
  logic          sys_clk, rst, psel, penable, pwrite, pready, pslverr, rd_err;
  logic          nmi_line, core_enter, core_return, nmi_enter, nmi_return;
  logic          irq_req, nmi_req, ctx_save, ctx_restore, irq_out;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd_data;
  logic [2:0]    irq_prio, irq_group;
  logic [N-1:0]  irq_line, raise, pulse, done;
  nip_id_t       core_enter_id, core_return_id, irq_id;
  int            num_errors, cmp_count;

  nip_top #(.NUM_SRC(N), .PRIO_W(3)) u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_line(irq_line), .nmi_line(nmi_line), .core_enter(core_enter), .core_enter_id(core_enter_id),
    .core_return(core_return), .core_return_id(core_return_id), .nmi_enter(nmi_enter), .nmi_return(nmi_return),
    .irq_req(irq_req), .irq_id(irq_id), .irq_prio(irq_prio), .irq_group(irq_group), .nmi_req(nmi_req),
    .ctx_save(ctx_save), .ctx_restore(ctx_restore), .irq_out(irq_out));
  nip_periph_model #(.N(N)) u_periph (.sys_clk(sys_clk), .rst(rst), .raise(raise), .pulse(pulse), .done(done),
    .irq_line(irq_line));

  // Free-running 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd_data, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle events, then settling time
  task automatic ev(input logic [6:0] k, input int id);
    @(posedge sys_clk);
    {nmi_line, nmi_enter, core_return, core_enter} <= k[3:0];
    core_enter_id <= 6'(id);
    core_return_id <= 6'(id);
    raise <= N'(k[4]) << id;
    pulse <= N'(k[5]) << id;
    done <= N'(k[6]) << id;
    @(posedge sys_clk);
    {nmi_line, nmi_enter, core_return, core_enter} <= 4'h0;
    {raise, pulse, done} <= '0;
    idle(3);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Ends a hang; tests need far less
  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {rst, psel, penable, pwrite, nmi_line, nmi_enter, nmi_return, core_enter, core_return} = 9'h100;
    {paddr, pwdata, core_enter_id, core_return_id, raise, pulse, done} = '0;
    num_errors = 0;
    cmp_count = 0;
    idle(12);
    rst <= 1'b0;
    rd(`NIP_OFS_EN0, 32'h00000000);
    rd(`NIP_OFS_MODE0, 32'h00000000);
    rd(12'h040, 32'h00000000);
    chk(rd_err, 32'h1);
    $display("Test registers done");
    // Level source held by its peripheral
    wr(`NIP_OFS_EN0, 32'h00000004);
    ev(lvl, 2);
    chk({irq_req, irq_id}, {1'b1, 6'h02});
    wr(`NIP_OFS_CLRP0, 32'h00000004);
    rd(`NIP_OFS_SETP0, 32'h00000004);
    ev(ent, 2);
    rd(`NIP_OFS_ACT0, 32'h00000004);
    rd(`NIP_OFS_SETP0, 32'h00000000);
    ev(ret, 2);
    rd(`NIP_OFS_SETP0, 32'h00000004);
    ev(ent | dne, 2);
    ev(ret, 2);
    rd(`NIP_OFS_ACT0, 32'h00000000);
    $display("Test level done");
    // Pulse source
    wr(`NIP_OFS_MODE0, 32'h00000020);
    wr(`NIP_OFS_EN0, 32'h00000024);
    ev(pls, 5);
    chk({irq_req, irq_id}, {1'b1, 6'h05});
    ev(ent, 5);
    ev(pls, 5);
    rd(`NIP_OFS_ACT0, 32'h00000020);
    ev(ret, 5);
    rd(`NIP_OFS_SETP0, 32'h00000020);
    ev(ent, 5);
    ev(pls, 5);
    wr(`NIP_OFS_CLRP0, 32'h00000020);
    rd(`NIP_OFS_SETP0, 32'h00000000);
    rd(`NIP_OFS_ACT0, 32'h00000020);
    ev(ret, 5);
    rd(`NIP_OFS_ACT0, 32'h00000000);
    ev(pls, 5);
    wr(`NIP_OFS_CLRP0, 32'h00000020);
    rd(`NIP_OFS_SETP0, 32'h00000000);
    $display("Test pulse done");
    // Priorities, software pending and grouping
    wr(`NIP_OFS_EN0, 32'h00000280);
    wr(`NIP_OFS_PRIO_BASE + 12'h01C, 32'h00000003);
    wr(`NIP_OFS_PRIO_BASE + 12'h024, 32'h00000001);
    wr(`NIP_OFS_SETP0, 32'h00000280);
    idle(3);
    chk({irq_req, irq_id}, {1'b1, 6'h09});
    wr(`NIP_OFS_PRIO_BASE + 12'h01C, 32'h00000001);
    idle(3);
    chk({irq_req, irq_id}, {1'b1, 6'h07});
    wr(`NIP_OFS_EN1, 32'h00000002);
    wr(`NIP_OFS_SOFTWARE_TRIGGER_REG, 32'h00000021);
    idle(3);
    chk({irq_req, irq_id}, {1'b1, 6'h21});
    wr(`NIP_OFS_PRIGRP, 32'h00000001);
    wr(`NIP_OFS_CLRP1, 32'h00000002);
    idle(3);
    chk({irq_id, irq_prio, irq_group}, {6'h07, 3'h1, 3'h0});
    wr(`NIP_OFS_CLRP0, 32'h00000280);
    idle(3);
    chk(irq_req, 32'h0);
    $display("Test priority done");
    // Event interrupt: raise, mask, clear
    wr(`NIP_OFS_IEN, 32'h00000002);
    idle(2);
    chk(irq_out, 32'h1);
    wr(`NIP_OFS_IEN, 32'h00000000);
    idle(2);
    chk(irq_out, 32'h0);
    ev(nln, 0);
    chk(nmi_req, 32'h1);
    ev(nen, 0);
    chk(nmi_req, 32'h0);
    rd(`NIP_OFS_ISTAT, 32'h0000000F);
    wr(`NIP_OFS_ICLR, 32'h0000000F);
    rd(`NIP_OFS_ISTAT, 32'h00000000);
    $display("Test events done");
    end_of_test();
  end
endmodule
